// File: include/dsc_pkg.sv
// Constants and types shared by the daylight-saving changeover engine.
package dsc_pkg;

    // ==========================================================
    // Register map, byte offsets on the APB bus
    localparam logic [3:0] DSC_OFF_CTRL = 4'h0;
    localparam logic [3:0] DSC_OFF_START = 4'h4;
    localparam logic [3:0] DSC_OFF_END = 4'h8;
    localparam logic [3:0] DSC_OFF_STATUS = 4'hc;

    // Status word bit positions.
    localparam int DSC_ST_START_DONE = 0;
    localparam int DSC_ST_END_DONE = 1;
    localparam int DSC_ST_SUMMER = 2;
    localparam int DSC_ST_RUNNING = 3;

    // ==========================================================
    // Modes and rule encodings
    typedef enum logic [2:0] {
        DSC_MODE_NONE = 3'h0,
        DSC_MODE_RULE = 3'h1,
        DSC_MODE_EU = 3'h2,
        DSC_MODE_GB = 3'h3,
        DSC_MODE_US = 3'h4
    } dsc_mode_t;

    localparam logic [1:0] DSC_KIND_DATE = 2'h0;
    localparam logic [1:0] DSC_KIND_NTH = 2'h1;
    localparam logic [1:0] DSC_KIND_AFTER = 2'h2;
    localparam logic [1:0] DSC_KIND_BEFORE = 2'h3;

    // Ordinal 0..3 is first..fourth, 4 is last.
    localparam logic [2:0] DSC_ORD_FIRST = 3'h0;
    localparam logic [2:0] DSC_ORD_FOURTH = 3'h3;
    localparam logic [2:0] DSC_ORD_LAST = 3'h4;

    // ==========================================================
    // Calendar limits
    localparam logic [3:0] DSC_JAN = 4'h1;
    localparam logic [3:0] DSC_FEB = 4'h2;
    localparam logic [3:0] DSC_MAR = 4'h3;
    localparam logic [3:0] DSC_APR = 4'h4;
    localparam logic [3:0] DSC_JUN = 4'h6;
    localparam logic [3:0] DSC_SEP = 4'h9;
    localparam logic [3:0] DSC_OCT = 4'ha;
    localparam logic [3:0] DSC_NOV = 4'hb;
    localparam logic [3:0] DSC_DEC = 4'hc;
    localparam logic [4:0] DSC_DAY_1 = 5'h01;
    localparam logic [4:0] DSC_DAY_28 = 5'h1c;
    localparam logic [4:0] DSC_DAY_29 = 5'h1d;
    localparam logic [4:0] DSC_DAY_30 = 5'h1e;
    localparam logic [4:0] DSC_DAY_31 = 5'h1f;
    localparam logic [4:0] DSC_HOUR_MAX = 5'h17;
    localparam logic [5:0] DSC_MIN_MAX = 6'h3b;
    localparam logic [2:0] DSC_WD_MAX = 3'h6;
    localparam logic [5:0] DSC_WEEK = 6'h07;
    // Offset in half hours, two's complement, legal -6..-1 and 1..6.
    localparam logic signed [3:0] DSC_OFS_MAX = 4'sh6;
    localparam logic signed [3:0] DSC_OFS_MIN = -4'sh6;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [3:0] shift_offset;
        logic [5:0] minute;
        logic [4:0] hour;
        logic [4:0] day;
        logic [3:0] month;
        logic [2:0] weekday_select;
        logic [2:0] ordinal;
        logic [1:0] kind;
    } dsc_rule_t;

    typedef struct packed {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [2:0] weekday;
        logic [4:0] hour;
        logic [5:0] minute;
    } dsc_time_t;

    typedef struct packed {
        dsc_mode_t mode;
        dsc_rule_t start_rule;
        dsc_rule_t end_rule;
        logic start_done;
        logic end_done;
        logic summer;
        logic [11:0] year;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic shift_valid;
        logic [3:0] shift_offset;
    } dsc_state_t;

    localparam dsc_state_t DSC_STATE_RST = '0;

    // Regional presets: start at 02:00 +1:00, end at 03:00 -1:00.
    localparam dsc_rule_t DSC_EU_START = '{shift_offset: 4'h2,
        minute: 6'h00, hour: 5'h02, day: 5'h00, month: DSC_MAR,
        weekday_select: 3'h0, ordinal: DSC_ORD_LAST, kind: DSC_KIND_NTH};
    localparam dsc_rule_t DSC_EU_END = '{shift_offset: 4'he,
        minute: 6'h00, hour: 5'h03, day: 5'h00, month: DSC_OCT,
        weekday_select: 3'h0, ordinal: DSC_ORD_LAST, kind: DSC_KIND_NTH};
    localparam dsc_rule_t DSC_GB_END = '{shift_offset: 4'he,
        minute: 6'h00, hour: 5'h03, day: 5'h00, month: DSC_OCT,
        weekday_select: 3'h0, ordinal: DSC_ORD_FOURTH,
        kind: DSC_KIND_NTH};
    localparam dsc_rule_t DSC_US_START = '{shift_offset: 4'h2,
        minute: 6'h00, hour: 5'h02, day: 5'h00, month: DSC_APR,
        weekday_select: 3'h0, ordinal: DSC_ORD_FIRST,
        kind: DSC_KIND_NTH};

endpackage

// File: hdl/dsc_rule_match.sv
// Day matcher: tells whether today is the day selected by one rule.
`timescale 1ns/1ps
module dsc_rule_match
    import dsc_pkg::*;
(
    // Rule and calendar.
    input dsc_rule_t rule,
    input dsc_time_t now,
    // Result.
    output logic day_hit
);

    // ==========================================================
    // Days in a month, with the leap-year February.
    function automatic logic [4:0] days_in(input logic [3:0] m,
                                           input logic leap);
        if (m == DSC_FEB) begin
            days_in = leap ? DSC_DAY_29 : DSC_DAY_28;
        end else if (m == DSC_APR || m == DSC_JUN || m == DSC_SEP ||
                     m == DSC_NOV) begin
            days_in = DSC_DAY_30;
        end else begin
            days_in = DSC_DAY_31;
        end
    endfunction

    logic leap;
    logic wd_eq;
    logic [3:0] next_m;
    logic [3:0] prev_m;
    logic [5:0] base;
    logic [5:0] d_after;
    logic [5:0] d_before;
    logic hit_date;
    logic hit_nth;

    // The calendar serves years 2000 to 2099, where every fourth is leap.
    assign leap = (now.year[1:0] == 2'h0);
    assign wd_eq = (now.weekday == rule.weekday_select);
    assign next_m = (rule.month == DSC_DEC) ? DSC_JAN : rule.month + 4'h1;
    assign prev_m = (rule.month == DSC_JAN) ? DSC_DEC : rule.month - 4'h1;
    assign base = 6'({rule.ordinal, 3'h0}) - 6'(rule.ordinal);

    // Distance in days from the rule date, across one month boundary.
    always_comb begin
        d_after = 6'h00;
        d_before = 6'h00;
        if (now.month == rule.month && now.day > rule.day) begin
            d_after = 6'(now.day - rule.day);
        end else if (now.month == next_m) begin
            d_after = 6'(now.day) + 6'(days_in(rule.month, leap)) -
                      6'(rule.day);
        end
        if (now.month == rule.month && now.day < rule.day) begin
            d_before = 6'(rule.day - now.day);
        end else if (now.month == prev_m) begin
            d_before = 6'(rule.day) + 6'(days_in(now.month, leap)) -
                       6'(now.day);
        end
    end

    // A 29 February date falls on 1 March in a common year.
    always_comb begin
        if (rule.month == DSC_FEB && rule.day == DSC_DAY_29 && !leap) begin
            hit_date = now.month == DSC_MAR && now.day == DSC_DAY_1;
        end else begin
            hit_date = now.month == rule.month && now.day == rule.day;
        end
    end

    // Nth weekday by week of the month, last by the final seven days.
    always_comb begin
        if (rule.ordinal == DSC_ORD_LAST) begin
            hit_nth = 6'(now.day) + DSC_WEEK >
                      6'(days_in(now.month, leap));
        end else begin
            hit_nth = 6'(now.day) > base &&
                      6'(now.day) <= base + DSC_WEEK;
        end
    end

    // Select the test for the rule kind.
    always_comb begin
        case (rule.kind)
            DSC_KIND_DATE: day_hit = hit_date;
            DSC_KIND_NTH: day_hit = wd_eq && hit_nth &&
                                    now.month == rule.month;
            DSC_KIND_AFTER: day_hit = wd_eq && d_after != 6'h00 &&
                                      d_after <= DSC_WEEK;
            default: day_hit = wd_eq && d_before != 6'h00 &&
                               d_before <= DSC_WEEK;
        endcase
    end

endmodule

// File: hdl/dsc_dst_engine.sv
// Daylight-saving changeover engine with its APB register file.
//
// Summary of operation
// - A fixed-date rule fires on a chosen day 1-31 of month 1-12.
// - A rule may pick first to fourth or last weekday of a month.
// - A rule may pick the first weekday strictly after or before a date.
// - Offset is signed half hours, 00:30 to 03:00, never zero.
// - European end: last Sunday October, 03:00 back to 02:00.
// - European start: last Sunday March, 02:00 forward to 03:00.
// - Mode is none, user rule or three presets; none after reset.
// - Start and end rules change only while the device is stopped.
// - A 29 February rule fires on 1 March in common years.
// - Time set past the end moment leaves summer_active as it was; no shift.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dsc_dst_engine
    import dsc_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Calendar side.
    input wire logic minute_tick,
    input dsc_time_t now,
    input wire logic device_running,
    // Changeover request to the calendar counter.
    output logic shift_valid,
    output logic [3:0] shift_offset,
    output logic summer_active
);

    // ==========================================================
    // Elaboration checks
    generate
        if (ADDR_W < 5) begin : g_bad_width
            $error("ADDR_W must be at least 5");
        end
    endgenerate

    // ==========================================================
    // Helpers
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [3:0] off);
        addr_is = (a == {{(ADDR_W-4){1'b0}}, off});
    endfunction

    // A rule word is taken only with every field in range.
    function automatic logic rule_ok(input dsc_rule_t r);
        rule_ok = r.month >= DSC_JAN && r.month <= DSC_DEC &&
                  r.day >= DSC_DAY_1 && r.hour <= DSC_HOUR_MAX &&
                  r.minute <= DSC_MIN_MAX &&
                  r.weekday_select <= DSC_WD_MAX &&
                  r.ordinal <= DSC_ORD_LAST &&
                  r.shift_offset != 4'h0 &&
                  $signed(r.shift_offset) <= DSC_OFS_MAX &&
                  $signed(r.shift_offset) >= DSC_OFS_MIN;
    endfunction

    // The rule in force for the mode; presets ignore the user words.
    function automatic dsc_rule_t pick_rule(input dsc_mode_t m,
                                            input dsc_rule_t user,
                                            input logic is_start);
        if (m == DSC_MODE_EU) begin
            pick_rule = is_start ? DSC_EU_START : DSC_EU_END;
        end else if (m == DSC_MODE_GB) begin
            pick_rule = is_start ? DSC_EU_START : DSC_GB_END;
        end else if (m == DSC_MODE_US) begin
            pick_rule = is_start ? DSC_US_START : DSC_EU_END;
        end else begin
            pick_rule = user;
        end
    endfunction

    // ==========================================================
    // State and rule evaluation
    dsc_state_t s_reg;
    dsc_state_t s_next;
    dsc_rule_t rs;
    dsc_rule_t re;
    logic start_hit;
    logic end_hit;
    logic start_fire;
    logic end_fire;
    logic year_new;
    logic dst_on;
    logic access;

    assign rs = pick_rule(s_reg.mode, s_reg.start_rule, 1'b1);
    assign re = pick_rule(s_reg.mode, s_reg.end_rule, 1'b0);

    dsc_rule_match u_start_match (
        .rule(rs),
        .now(now),
        .day_hit(start_hit)
    );

    dsc_rule_match u_end_match (
        .rule(re),
        .now(now),
        .day_hit(end_hit)
    );

    // A rule fires only on the tick at its exact minute, once a year.
    assign year_new = (now.year != s_reg.year);
    assign dst_on = (s_reg.mode != DSC_MODE_NONE);
    assign start_fire = minute_tick && dst_on && start_hit &&
                        now.hour == rs.hour && now.minute == rs.minute &&
                        (year_new || !s_reg.start_done);
    // A clock already set past the end minute never matches it.
    assign end_fire = minute_tick && dst_on && end_hit && !start_fire &&
                      now.hour == re.hour && now.minute == re.minute &&
                      (year_new || !s_reg.end_done);
    assign access = psel && penable;

    // Next-state logic: bus access, year rollover and changeover.
    always_comb begin
        s_next = s_reg;
        s_next.shift_valid = 1'b0;
        if (access && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.err = 1'b0;
            s_next.rdata = '0;
            if (addr_is(paddr, DSC_OFF_CTRL)) begin
                if (pwrite) begin
                    s_next.err = pwdata[31:3] != '0 ||
                                 pwdata[2:0] > DSC_MODE_US;
                end else begin
                    s_next.rdata = 32'(s_reg.mode);
                end
            end else if (addr_is(paddr, DSC_OFF_START)) begin
                if (pwrite) begin
                    s_next.err = device_running || !rule_ok(pwdata);
                end else begin
                    s_next.rdata = s_reg.start_rule;
                end
            end else if (addr_is(paddr, DSC_OFF_END)) begin
                if (pwrite) begin
                    s_next.err = device_running || !rule_ok(pwdata);
                end else begin
                    s_next.rdata = s_reg.end_rule;
                end
            end else if (addr_is(paddr, DSC_OFF_STATUS)) begin
                s_next.err = pwrite;
                s_next.rdata[DSC_ST_START_DONE] = s_reg.start_done;
                s_next.rdata[DSC_ST_END_DONE] = s_reg.end_done;
                s_next.rdata[DSC_ST_SUMMER] = s_reg.summer;
                s_next.rdata[DSC_ST_RUNNING] = device_running;
            end else begin
                s_next.err = 1'b1;
            end
        end else if (access) begin
            s_next.ack = 1'b0;
            if (pwrite && !s_reg.err) begin
                if (addr_is(paddr, DSC_OFF_CTRL)) begin
                    s_next.mode = dsc_mode_t'(pwdata[2:0]);
                end else if (addr_is(paddr, DSC_OFF_START)) begin
                    s_next.start_rule = pwdata;
                end else if (addr_is(paddr, DSC_OFF_END)) begin
                    s_next.end_rule = pwdata;
                end
            end
        end else begin
            s_next.ack = 1'b0;
        end
        // A new year re-arms both rules; a firing in that cycle wins.
        if (year_new) begin
            s_next.year = now.year;
            s_next.start_done = 1'b0;
            s_next.end_done = 1'b0;
        end
        if (start_fire) begin
            s_next.start_done = 1'b1;
            s_next.summer = 1'b1;
            s_next.shift_valid = 1'b1;
            s_next.shift_offset = rs.shift_offset;
        end else if (end_fire) begin
            s_next.end_done = 1'b1;
            s_next.summer = 1'b0;
            s_next.shift_valid = 1'b1;
            s_next.shift_offset = re.shift_offset;
        end
    end

    // State register.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= DSC_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs; pready comes one wait state into the access phase.
    assign prdata = s_reg.rdata;
    assign pready = access && s_reg.ack;
    assign pslverr = s_reg.err;
    assign shift_valid = s_reg.shift_valid;
    assign shift_offset = s_reg.shift_offset;
    assign summer_active = s_reg.summer;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_cfg_setup_running;
        access && !s_reg.ack && pwrite && device_running &&
        (addr_is(paddr, DSC_OFF_START) || addr_is(paddr, DSC_OFF_END));
    endsequence

    sequence s_cfg_refused;
        pready && pslverr;
    endsequence

    a_mode_reset_none: assert property (
        $past(sys_rst) |-> s_reg.mode == DSC_MODE_NONE)
        else $error("mode not none after reset");

    a_cfg_refused_run: assert property (
        s_cfg_setup_running |=> s_cfg_refused ##1 $stable(s_reg.start_rule)
        && $stable(s_reg.end_rule))
        else $error("rule write accepted while running");

    a_shift_on_tick: assert property (
        shift_valid |-> $past(minute_tick) && $past(dst_on))
        else $error("shift without minute tick");

    a_offset_legal: assert property (
        shift_valid |-> shift_offset != 4'h0 &&
        $signed(shift_offset) <= DSC_OFS_MAX &&
        $signed(shift_offset) >= DSC_OFS_MIN)
        else $error("illegal shift offset");

    a_eu_end_back: assert property (
        s_reg.mode == DSC_MODE_EU && end_fire |-> now.month == DSC_OCT &&
        now.hour == 5'h03 ##1 shift_valid && shift_offset == 4'he &&
        !summer_active)
        else $error("EU end changeover wrong");

    a_eu_start_fwd: assert property (
        s_reg.mode == DSC_MODE_EU && start_fire |-> now.month == DSC_MAR &&
        now.hour == 5'h02 ##1 shift_valid && shift_offset == 4'h2 &&
        summer_active)
        else $error("EU start changeover wrong");

    a_once_per_year: assert property (
        start_fire && !year_new |-> !s_reg.start_done ##1
        s_reg.start_done [*2])
        else $error("start rule fired twice");

    a_end_exact_min: assert property (
        shift_valid && !summer_active |-> $past(end_hit) &&
        $past(now.hour) == $past(re.hour) &&
        $past(now.minute) == $past(re.minute))
        else $error("end shift away from its minute");

    a_fixed_date_hit: assert property (
        start_hit && rs.kind == DSC_KIND_DATE && rs.day != DSC_DAY_29 |->
        now.month == rs.month && now.day == rs.day)
        else $error("fixed date mismatch");

    a_feb29_march: assert property (
        rs.kind == DSC_KIND_DATE && rs.month == DSC_FEB &&
        rs.day == DSC_DAY_29 && now.year[1:0] != 2'h0 &&
        now.month == DSC_MAR && now.day == DSC_DAY_1 |-> start_hit)
        else $error("29 February not moved to 1 March");

    a_weekday_kinds: assert property (
        start_hit && rs.kind != DSC_KIND_DATE |->
        now.weekday == rs.weekday_select)
        else $error("weekday rule hit on wrong weekday");

    // The answer comes after exactly one wait state and lasts one cycle.
    a_pready_wait: assert property (
        access && !s_reg.ack |=> pready ##1 !pready)
        else $error("pready not after one wait state");

    // A shift request is a single-cycle pulse.
    a_shift_pulse: assert property (
        shift_valid |=> !shift_valid)
        else $error("shift request longer than one cycle");

    // A start firing marks the rule done and enters summer time.
    a_start_done: assert property (
        start_fire |=> summer_active && s_reg.start_done)
        else $error("start firing not recorded");

    // With no changeover mode nothing is ever shifted.
    a_none_no_shift: assert property (
        s_reg.mode == DSC_MODE_NONE |=> !shift_valid)
        else $error("shift requested in mode none");

    // A refused mode write leaves the mode as it was.
    a_mode_err_keep: assert property (
        pready && pslverr && pwrite && addr_is(paddr, DSC_OFF_CTRL) |=>
        $stable(s_reg.mode))
        else $error("refused mode write changed the mode");

endmodule

// File: dv/dsc_dst_engine_tb.sv
// Self-checking testbench for the daylight-saving changeover engine.
`timescale 1ns/1ps
module dsc_dst_engine_tb;
    import dsc_pkg::*;
    // ==========================================================
    // Signals and design instance
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic minute_tick = 1'b0;
    dsc_time_t now = '0;
    logic device_running = 1'b0;
    logic shift_valid;
    logic [3:0] shift_offset;
    logic summer_active;
    int n_errors = 0;
    int cmp_count = 0;

    dsc_dst_engine i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .minute_tick(minute_tick), .now(now),
        .device_running(device_running), .shift_valid(shift_valid),
        .shift_offset(shift_offset), .summer_active(summer_active));

    // The clock toggles every half period of 100 ns.
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Calendar helpers
    // Weekday of a date, 0 is Sunday.
    function automatic int wday(int y, int m, int d);
        int t[12] = '{0, 3, 2, 5, 0, 3, 5, 1, 4, 6, 2, 4};
        if (m < 3) y = y - 1;
        return (y + y / 4 - y / 100 + y / 400 + t[m - 1] + d) % 7;
    endfunction
    function automatic int mdays(int y, int m);
        if (m == 2) return (y % 4 == 0) ? 29 : 28;
        return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
    endfunction
    // Day of month on which a rule should fire.
    function automatic int tday(int k, int o, int w, int y, int m, int d);
        int n;
        if (k == 0) return d;
        if (k == 2) return d + 1 + (w - wday(y, m, d + 1) + 7) % 7;
        if (k == 3) return d - 1 - (wday(y, m, d - 1) - w + 7) % 7;
        if (o == 4) begin
            n = mdays(y, m);
            return n - (wday(y, m, n) - w + 7) % 7;
        end
        return 1 + (w - wday(y, m, 1) + 7) % 7 + 7 * o;
    endfunction
    function automatic dsc_time_t tm(int y, int m, int d, int h, int n);
        dsc_time_t t;
        t.year = 12'(y);
        t.month = 4'(m);
        t.day = 5'(d);
        t.weekday = 3'(wday(y, m, d));
        t.hour = 5'(h);
        t.minute = 6'(n);
        return t;
    endfunction

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; pready, read data and pslverr are taken at the
    // rising edge that completes the access, and only then released.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        chk("pready wait states", 32'h1, 32'(n));
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("pslverr write", {31'h0, ee}, {31'h0, e});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("pslverr read", {31'h0, ee}, {31'h0, e});
        if (!ee) chk("prdata", x, r);
    endtask
    // Presents a time, pulses the minute tick, checks the shift pulse.
    task automatic tick(input dsc_time_t t, input logic ex,
                        input logic [3:0] ofs, input logic sm);
        @(posedge ref_clk);
        now <= t;
        @(posedge ref_clk);
        minute_tick <= 1'b1;
        @(posedge ref_clk);
        minute_tick <= 1'b0;
        #1;
        chk("shift_valid", {31'h0, ex}, {31'h0, shift_valid});
        if (ex) chk("shift_offset", {28'h0, ofs}, {28'h0, shift_offset});
        if (ex) chk("summer_active", {31'h0, sm}, {31'h0, summer_active});
        @(posedge ref_clk);
        #1;
        chk("shift_valid pulse", 32'h0, {31'h0, shift_valid});
    endtask

    // ==========================================================
    // Hang guard, reckoned at a few thousand cycles.
    initial begin
        #(4000 * 100);
        n_errors++;
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        int k, o, y, m, w, d, h, n, s, fd, fm, fe;
        dsc_rule_t rw;
        void'($urandom(96620));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(12'(DSC_OFF_CTRL), 32'h0, 1'b0);
        rd(12'(DSC_OFF_STATUS), 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        for (int md = 0; md < 5; md++) begin
            wr(12'(DSC_OFF_CTRL), 32'(md), 1'b0);
            rd(12'(DSC_OFF_CTRL), 32'(md), 1'b0);
        end
        wr(12'(DSC_OFF_CTRL), 32'h5, 1'b1);
        wr(12'(DSC_OFF_CTRL), 32'(DSC_MODE_RULE), 1'b0);
        // Every rule kind and ordinal fires once per fresh year.
        for (int i = 0; i < 9; i++) begin
            k = (i == 0 || i == 8) ? 0 : (i < 6) ? 1 : i - 4;
            o = (i >= 1 && i <= 5) ? i - 1 : 0;
            y = 2001 + 11 * i + $urandom_range(0, 9);
            if (i == 8 && y % 4 == 0) y++;
            m = (i == 8) ? 2 : $urandom_range(1, 12);
            w = $urandom_range(0, 6);
            d = (i == 8) ? 29 : $urandom_range(9, 20);
            h = $urandom_range(0, 23);
            n = $urandom_range(1, 59);
            s = $urandom_range(1, 6);
            if ($urandom_range(0, 1) == 1) s = -s;
            fd = (i == 8) ? 1 : tday(k, o, w, y, m, d);
            fm = (i == 8) ? 3 : m;
            rw = '{shift_offset: 4'(s), minute: 6'(n), hour: 5'(h),
                day: 5'(d), month: 4'(m), weekday_select: 3'(w),
                ordinal: 3'(o), kind: 2'(k)};
            wr(12'(DSC_OFF_START), rw, 1'b0);
            tick(tm(y, fm, fd, h, n - 1), 1'b0, 4'h0, 1'b0);
            tick(tm(y, fm, (fd > 14) ? fd - 7 : fd + 7, h, n), 1'b0,
                4'h0, 1'b0);
            tick(tm(y, fm, fd, h, n), 1'b1, 4'(s), 1'b1);
            tick(tm(y, fm, fd, h, n), 1'b0, 4'h0, 1'b0);
        end
        // Rule words are locked while running and checked for range.
        @(posedge ref_clk);
        device_running <= 1'b1;
        wr(12'(DSC_OFF_START), 32'h2000_1101, 1'b1);
        rd(12'(DSC_OFF_START), rw, 1'b0);
        rd(12'(DSC_OFF_STATUS), 32'hd, 1'b0);
        @(posedge ref_clk);
        device_running <= 1'b0;
        wr(12'(DSC_OFF_START), 32'h0000_1101, 1'b1);
        wr(12'(DSC_OFF_START), 32'h7000_1101, 1'b1);
        wr(12'(DSC_OFF_START), 32'h9000_1101, 1'b1);
        wr(12'(DSC_OFF_START), 32'h2000_1d01, 1'b1);
        wr(12'(DSC_OFF_START), 32'h2030_1101, 1'b1);
        wr(12'(DSC_OFF_START), 32'ha000_1100, 1'b0);
        rd(12'(DSC_OFF_START), 32'ha000_1100, 1'b0);
        // European preset across a year and a manual set past the end.
        wr(12'(DSC_OFF_CTRL), 32'(DSC_MODE_EU), 1'b0);
        fd = tday(1, 4, 0, 2000, 3, 1);
        fe = tday(1, 4, 0, 2000, 10, 1);
        tick(tm(2000, 3, fd, 2, 0), 1'b1, 4'h2, 1'b1);
        tick(tm(2000, 10, fe, 3, 0), 1'b1, 4'he, 1'b0);
        rd(12'(DSC_OFF_STATUS), 32'h3, 1'b0);
        tick(tm(2000, 10, fe, 3, 0), 1'b0, 4'h0, 1'b0);
        fe = tday(1, 4, 0, 1999, 10, 1);
        tick(tm(1999, 10, fe, 3, 5), 1'b0, 4'h0, 1'b0);
        tick(tm(1999, 10, fe - 7, 3, 0), 1'b0, 4'h0, 1'b0);
        complete_run();
    end
endmodule
